// ==== common/psc_cfg.svh ====
// Constants for the port statistics counter block
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define PSC_LEN_W        14
`define PSC_COLL_W       5
`define PSC_CNT_W        32
`define PSC_ADDR_W       5
`define PSC_NUM_CNT      25

// ----------------------------------------------------------------------
// Counter indices on the read port
// ----------------------------------------------------------------------
`define PSC_IX_TX_GOOD   5'h00
`define PSC_IX_TX_MCAST  5'h01
`define PSC_IX_TX_BCAST  5'h02
`define PSC_IX_TX_PAUSE  5'h03
`define PSC_IX_TX_VLAN   5'h04
`define PSC_IX_RX_GOOD   5'h05
`define PSC_IX_RX_MCAST  5'h06
`define PSC_IX_RX_BCAST  5'h07
`define PSC_IX_RX_PAUSE  5'h08
`define PSC_IX_RX_CTRL   5'h09
`define PSC_IX_COL_ONE   5'h0a
`define PSC_IX_COL_MULTI 5'h0b
`define PSC_IX_COL_EXC   5'h0c
`define PSC_IX_COL_LATE  5'h0d
`define PSC_IX_RX_CRC    5'h0e
`define PSC_IX_RX_LEN    5'h0f
`define PSC_IX_RX_RUNT   5'h10
`define PSC_IX_BIN_64    5'h11
`define PSC_IX_BIN_127   5'h12
`define PSC_IX_BIN_255   5'h13
`define PSC_IX_BIN_511   5'h14
`define PSC_IX_BIN_1023  5'h15
`define PSC_IX_BIN_1518  5'h16
`define PSC_IX_GIANT     5'h17
`define PSC_IX_UPTIME    5'h18

// ----------------------------------------------------------------------
// Frame size limits in octets
// ----------------------------------------------------------------------
`define PSC_LEN_64       14'h0040
`define PSC_LEN_127      14'h007f
`define PSC_LEN_128      14'h0080
`define PSC_LEN_255      14'h00ff
`define PSC_LEN_256      14'h0100
`define PSC_LEN_511      14'h01ff
`define PSC_LEN_512      14'h0200
`define PSC_LEN_1023     14'h03ff
`define PSC_LEN_1024     14'h0400
`define PSC_LEN_1518     14'h05ee
`define PSC_MAX_FRAME    14'h05ee

// ----------------------------------------------------------------------
// Collision counts and timing
// ----------------------------------------------------------------------
`define PSC_COLL_NONE    5'h00
`define PSC_COLL_ONE     5'h01
`define PSC_CLK_MHZ      100
`define PSC_UPTIME_MS    1000

`endif

// ==== common/psc_pkg.sv ====
// Types shared by the port statistics counter block
package psc_pkg;

  // ----------------------------------------------------------------------
  // Transmit completion report from the MAC
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       good;     // Frame sent successfully
    logic       mcast;    // Multicast destination
    logic       bcast;    // Broadcast destination
    logic       pause;    // Flow-control pause frame
    logic       vlan;     // Frame carried a VLAN tag
    logic       excess;   // Abandoned at collision limit
    logic [4:0] coll_cnt; // Collisions before success
  } psc_tx_evt_t;

  // ----------------------------------------------------------------------
  // Receive completion report from the MAC
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        crc_err; // Frame check sequence failed
    logic        len_err; // Length field out of range
    logic        mcast;   // Multicast destination
    logic        bcast;   // Broadcast destination
    logic        pause;   // Flow-control pause frame
    logic        ctrl;    // MAC control frame
    logic [13:0] len;     // Frame length in octets
  } psc_rx_evt_t;

endpackage

// ==== hw/psc_cnt_bank.sv ====
// Bank of wrapping event counters with a registered read port
`timescale 1ns/10ps
`include "psc_cfg.svh"

module psc_cnt_bank #(
  parameter int N = `PSC_NUM_CNT,
  parameter int W = `PSC_CNT_W,
  parameter int A = `PSC_ADDR_W
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         clr_i,
  input  wire logic [N-1:0] inc_i,
  input  wire logic         rd_en_i,
  input  wire logic [A-1:0] rd_addr_i,
  output logic      [W-1:0] rd_data_o,
  output logic              rd_valid_o
);

  logic [W-1:0] cnt_reg [N];
  logic [W-1:0] rd_data_reg;
  logic         rd_valid_reg;
  wire          addr_ok = (32'(rd_addr_i) < N);
  wire  [W-1:0] rd_sel  = addr_ok ? cnt_reg[rd_addr_i] : '0;

  // ----------------------------------------------------------------------
  // One counter per event; clear beats a same-cycle increment
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_cnt
    always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || (ce_i && clr_i)) begin
        cnt_reg[i] <= '0;                     // see [RQ22]
      end else if (ce_i && inc_i[i]) begin
        cnt_reg[i] <= cnt_reg[i] + 1'b1;      // Wraps at all ones, see [RQ23]
      end
    end
  end

  // Read is side-effect free; unmapped indices answer zero
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_data_reg  <= '0;
      rd_valid_reg <= 1'b0;
    end else if (ce_i) begin
      rd_valid_reg <= rd_en_i;
      if (rd_en_i) begin
        rd_data_reg <= rd_sel;                // see [RQ23]
      end
    end
  end

  assign rd_data_o  = rd_data_reg;
  assign rd_valid_o = rd_valid_reg;

  AST_READ_DATA: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && rd_en_i && addr_ok && !clr_i && !inc_i[rd_addr_i]
    |=> rd_valid_o && rd_data_o == cnt_reg[$past(rd_addr_i)]) // see [RQ23]
    else $error("Read data does not match the addressed counter");

endmodule

// ==== hw/psc_port_stats.sv ====
// Per-port Ethernet statistics counters: frames, collisions, errors, sizes
//
// Overview of operation
// [RQ1] Count every good transmitted frame
// [RQ2] Count good transmitted multicast frames
// [RQ3] Count good transmitted broadcast frames
// [RQ4] Count transmitted pause frames
// [RQ5] Count transmitted VLAN-tagged frames
// [RQ6] Count every good received frame
// [RQ7] Count good received multicast frames
// [RQ8] Count good received broadcast frames
// [RQ9] Count received pause frames
// [RQ10] Count received control frames, pause excluded
// [RQ11] Count successes after exactly one collision
// [RQ12] Count successes after two or more collisions
// [RQ13] Count frames abandoned at collision limit
// [RQ14] Count late collisions past 512 bits
// [RQ15] Count received frames failing CRC
// [RQ16] Count received frames with length out of range
// [RQ17] Count received frames under 64 octets
// [RQ18] Histogram bin for 64-octet frames
// [RQ19] Histogram bins up to 1518 octets
// [RQ20] Drop and count frames above maximum size
// [RQ21] Accumulate link up time
// [RQ22] Clear command zeroes this port's counters
// [RQ23] Counters wrap and reads change nothing
`timescale 1ns/10ps
`include "psc_cfg.svh"

module psc_port_stats #(
  parameter int          CNT_W    = `PSC_CNT_W,
  parameter logic [7:0]  PORT_ID  = 8'h00,
  parameter int unsigned TICK_CYC = `PSC_UPTIME_MS * 1000 * `PSC_CLK_MHZ
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   ce_i,
  input  wire logic                   tx_done_i,
  input  wire psc_pkg::psc_tx_evt_t   tx_evt_i,
  input  wire logic                   tx_late_coll_i,
  input  wire logic                   rx_done_i,
  input  wire psc_pkg::psc_rx_evt_t   rx_evt_i,
  input  wire logic [`PSC_LEN_W-1:0]  max_frame_i,
  input  wire logic                   link_up_i,
  input  wire logic                   clr_port_i,
  input  wire logic                   clr_all_i,
  input  wire logic [7:0]             clr_sel_i,
  input  wire logic                   rd_en_i,
  input  wire logic [`PSC_ADDR_W-1:0] rd_addr_i,
  output logic      [CNT_W-1:0]       rd_data_o,
  output logic                        rd_valid_o,
  output logic                        rx_drop_o,
  output logic                        link_up_o
);

  localparam int N = `PSC_NUM_CNT;

  // ----------------------------------------------------------------------
  // Link status pin synchroniser
  // ----------------------------------------------------------------------
  logic link_meta_reg;
  logic link_sync_reg;

  // The pin comes from the PHY, outside this clock's domain
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      link_meta_reg <= 1'b0;
      link_sync_reg <= 1'b0;
    end else if (ce_i) begin
      link_meta_reg <= link_up_i;
      link_sync_reg <= link_meta_reg;
    end
  end

  assign link_up_o = link_sync_reg;

  // ----------------------------------------------------------------------
  // Transmit classification
  // ----------------------------------------------------------------------
  wire tx_ok     = tx_done_i && tx_evt_i.good;
  wire tx_mc     = tx_ok && tx_evt_i.mcast;                 // see [RQ2]
  wire tx_bc     = tx_ok && tx_evt_i.bcast;                 // see [RQ3]
  wire tx_pause  = tx_done_i && tx_evt_i.pause;             // see [RQ4]
  wire tx_vlan   = tx_done_i && tx_evt_i.vlan;              // see [RQ5]
  wire col_one   = tx_ok && tx_evt_i.coll_cnt == `PSC_COLL_ONE; // see [RQ11]
  wire col_multi = tx_ok && tx_evt_i.coll_cnt > `PSC_COLL_ONE;  // see [RQ12]
  // The MAC resets its own retry count when it gives up
  wire col_exc   = tx_done_i && tx_evt_i.excess;            // see [RQ13]
  // The MAC flags a collision only once 512 bits have left the port
  wire col_late  = tx_late_coll_i;                          // see [RQ14]

  // ----------------------------------------------------------------------
  // Receive classification
  // ----------------------------------------------------------------------
  wire [`PSC_LEN_W-1:0] rx_len = rx_evt_i.len;

  // Oversize frames are dropped, so they never count as good
  wire rx_giant  = rx_done_i && rx_len > max_frame_i;       // see [RQ20]
  wire rx_ok     = rx_done_i && !rx_evt_i.crc_err && !rx_evt_i.len_err
                   && !rx_giant && rx_len >= `PSC_LEN_64;
  wire rx_mc     = rx_ok && rx_evt_i.mcast;                 // see [RQ7]
  wire rx_bc     = rx_ok && rx_evt_i.bcast;                 // see [RQ8]
  wire rx_pause  = rx_done_i && rx_evt_i.pause;             // see [RQ9]
  // Bad-CRC control frames still count here; pause has its own
  wire rx_ctrl   = rx_done_i && rx_evt_i.ctrl && !rx_evt_i.pause; // see [RQ10]
  wire rx_crc    = rx_done_i && rx_evt_i.crc_err;           // see [RQ15]
  wire rx_lenerr = rx_done_i && rx_evt_i.len_err;           // see [RQ16]
  wire rx_runt   = rx_done_i && rx_len < `PSC_LEN_64;       // see [RQ17]

  // Size bins include bad frames
  wire bin_64    = rx_done_i && rx_len == `PSC_LEN_64;      // see [RQ18]
  wire bin_127   = rx_done_i && rx_len > `PSC_LEN_64
                   && rx_len <= `PSC_LEN_127;               // see [RQ19]
  wire bin_255   = rx_done_i && rx_len >= `PSC_LEN_128
                   && rx_len <= `PSC_LEN_255;               // see [RQ19]
  wire bin_511   = rx_done_i && rx_len >= `PSC_LEN_256
                   && rx_len <= `PSC_LEN_511;               // see [RQ19]
  wire bin_1023  = rx_done_i && rx_len >= `PSC_LEN_512
                   && rx_len <= `PSC_LEN_1023;              // see [RQ19]
  wire bin_1518  = rx_done_i && rx_len >= `PSC_LEN_1024
                   && rx_len <= `PSC_LEN_1518;              // see [RQ19]

  // ----------------------------------------------------------------------
  // Up time prescaler
  // ----------------------------------------------------------------------
  localparam int unsigned TICK_LAST = TICK_CYC - 1;

  logic [31:0] tick_reg;
  logic [31:0] tick_next;
  wire         tick_wrap = tick_reg == TICK_LAST[31:0];
  wire         up_tick   = link_sync_reg && tick_wrap;      // see [RQ21]

  // Prescaler only runs while the link is up, so partial periods carry
  always_comb begin
    tick_next = tick_reg;
    if (link_sync_reg) begin
      tick_next = tick_wrap ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Clear command decode
  // ----------------------------------------------------------------------
  wire clr_hit = clr_all_i || (clr_port_i && clr_sel_i == PORT_ID); // see [RQ22]

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || (ce_i && clr_hit)) begin
      tick_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      tick_reg <= tick_next;
    end
  end

  // ----------------------------------------------------------------------
  // Increment vector, one bit per counter index
  // ----------------------------------------------------------------------
  logic [N-1:0] inc_vec;

  always_comb begin
    inc_vec                     = '0;
    inc_vec[`PSC_IX_TX_GOOD]    = tx_ok;                    // see [RQ1]
    inc_vec[`PSC_IX_TX_MCAST]   = tx_mc;
    inc_vec[`PSC_IX_TX_BCAST]   = tx_bc;
    inc_vec[`PSC_IX_TX_PAUSE]   = tx_pause;
    inc_vec[`PSC_IX_TX_VLAN]    = tx_vlan;
    inc_vec[`PSC_IX_RX_GOOD]    = rx_ok;                    // see [RQ6]
    inc_vec[`PSC_IX_RX_MCAST]   = rx_mc;
    inc_vec[`PSC_IX_RX_BCAST]   = rx_bc;
    inc_vec[`PSC_IX_RX_PAUSE]   = rx_pause;
    inc_vec[`PSC_IX_RX_CTRL]    = rx_ctrl;
    inc_vec[`PSC_IX_COL_ONE]    = col_one;
    inc_vec[`PSC_IX_COL_MULTI]  = col_multi;
    inc_vec[`PSC_IX_COL_EXC]    = col_exc;
    inc_vec[`PSC_IX_COL_LATE]   = col_late;
    inc_vec[`PSC_IX_RX_CRC]     = rx_crc;
    inc_vec[`PSC_IX_RX_LEN]     = rx_lenerr;
    inc_vec[`PSC_IX_RX_RUNT]    = rx_runt;
    inc_vec[`PSC_IX_BIN_64]     = bin_64;
    inc_vec[`PSC_IX_BIN_127]    = bin_127;
    inc_vec[`PSC_IX_BIN_255]    = bin_255;
    inc_vec[`PSC_IX_BIN_511]    = bin_511;
    inc_vec[`PSC_IX_BIN_1023]   = bin_1023;
    inc_vec[`PSC_IX_BIN_1518]   = bin_1518;
    inc_vec[`PSC_IX_GIANT]      = rx_giant;                 // see [RQ20]
    inc_vec[`PSC_IX_UPTIME]     = up_tick;                  // see [RQ21]
  end

  // ----------------------------------------------------------------------
  // Drop strobe to the receive path
  // ----------------------------------------------------------------------
  logic drop_reg;

  // Registered so the receive path sees a clean one-cycle pulse
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      drop_reg <= 1'b0;
    end else if (ce_i) begin
      drop_reg <= rx_giant;                                 // see [RQ20]
    end
  end

  assign rx_drop_o = drop_reg;

  // ----------------------------------------------------------------------
  // Counter storage
  // ----------------------------------------------------------------------
  psc_cnt_bank #(
    .N (N),
    .W (CNT_W),
    .A (`PSC_ADDR_W)
  ) u_bank (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .clr_i      (clr_hit),
    .inc_i      (inc_vec),
    .rd_en_i    (rd_en_i),
    .rd_addr_i  (rd_addr_i),
    .rd_data_o  (rd_data_o),
    .rd_valid_o (rd_valid_o)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_TX_GOOD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    tx_done_i && tx_evt_i.good |-> inc_vec[`PSC_IX_TX_GOOD]) // see [RQ1]
    else $error("Good transmit frame not counted");

  AST_TX_MCAST: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    inc_vec[`PSC_IX_TX_MCAST] |-> inc_vec[`PSC_IX_TX_GOOD]
    && tx_evt_i.mcast) // see [RQ2]
    else $error("Transmit multicast count without a good frame");

  AST_TX_BCAST: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    tx_done_i && tx_evt_i.good && tx_evt_i.bcast
    |-> inc_vec[`PSC_IX_TX_BCAST]) // see [RQ3]
    else $error("Transmit broadcast frame not counted");

  AST_RX_GOOD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    inc_vec[`PSC_IX_RX_GOOD] |-> !rx_evt_i.crc_err
    && rx_len <= max_frame_i) // see [RQ6]
    else $error("Bad or oversize frame counted as good");

  AST_RX_CTRL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rx_done_i && rx_evt_i.ctrl && rx_evt_i.crc_err && !rx_evt_i.pause
    |-> inc_vec[`PSC_IX_RX_CTRL] && inc_vec[`PSC_IX_RX_CRC]) // see [RQ10]
    else $error("Control frame with bad CRC not counted");

  AST_COLL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    tx_done_i && tx_evt_i.good && tx_evt_i.coll_cnt != `PSC_COLL_NONE
    |-> inc_vec[`PSC_IX_COL_ONE] != inc_vec[`PSC_IX_COL_MULTI]) // see [RQ11]
    else $error("Collision success not counted exactly once");

  AST_RUNT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rx_done_i && rx_len < `PSC_LEN_64 |-> inc_vec[`PSC_IX_RX_RUNT]
    && !inc_vec[`PSC_IX_BIN_64] && !inc_vec[`PSC_IX_RX_GOOD]) // see [RQ17]
    else $error("Runt frame miscounted");

  AST_BIN_ONE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rx_done_i && rx_len >= `PSC_LEN_64 && rx_len <= `PSC_LEN_1518
    |-> $onehot(inc_vec[`PSC_IX_BIN_1518:`PSC_IX_BIN_64])) // see [RQ19]
    else $error("Sized frame not counted in exactly one bin");

  AST_GIANT_DROP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && rx_done_i && rx_len > max_frame_i
    |=> rx_drop_o ##1 !rx_drop_o || $past(rx_giant)) // see [RQ20]
    else $error("Oversize frame not dropped");

  AST_UPTIME: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    up_tick |-> link_sync_reg && tick_reg == TICK_LAST[31:0]) // see [RQ21]
    else $error("Up time advanced without a full period of link up");

  AST_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && clr_all_i |=> tick_reg == 32'h0000_0000) // see [RQ22]
    else $error("Clear did not reset the up time prescaler");

  // Counter-level checks look into the bank, so a wrong index shows up
  AST_VLAN_INC: assert property ( // see [RQ5]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && !clr_hit && tx_vlan |=> u_bank.cnt_reg[`PSC_IX_TX_VLAN] ==
    CNT_W'($past(u_bank.cnt_reg[`PSC_IX_TX_VLAN]) + 1'b1))
    else $error("Tagged transmit frame not counted");

  AST_EXC_INC: assert property ( // see [RQ13]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && !clr_hit && col_exc |=> u_bank.cnt_reg[`PSC_IX_COL_EXC] ==
    CNT_W'($past(u_bank.cnt_reg[`PSC_IX_COL_EXC]) + 1'b1))
    else $error("Abandoned frame not counted");

  AST_LATE_INC: assert property ( // see [RQ14]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && !clr_hit && col_late |=> u_bank.cnt_reg[`PSC_IX_COL_LATE] ==
    CNT_W'($past(u_bank.cnt_reg[`PSC_IX_COL_LATE]) + 1'b1))
    else $error("Late collision not counted");

  AST_LINK_SYNC: assert property ( // see [RQ21]
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i |=> link_up_o == $past(link_meta_reg))
    else $error("Link level skipped the second flop");

endmodule

// ==== hw/psc_unused_placeholder_none.sv ====
// Holds no logic; the block is the statistics top and its counter bank

// ==== bench/psc_mac_model.sv ====
// Behavioural port MAC that issues transmit and receive completion reports
`timescale 1ns/10ps

module psc_mac_model (
  input  wire logic            core_clk_i,
  output logic                 tx_done_o,
  output psc_pkg::psc_tx_evt_t tx_evt_o,
  output logic                 tx_late_o,
  output logic                 rx_done_o,
  output psc_pkg::psc_rx_evt_t rx_evt_o,
  output logic                 link_up_o
);
  // ----------------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------------
  initial begin
    tx_done_o = 1'b0;
    tx_evt_o  = '0;
    tx_late_o = 1'b0;
    rx_done_o = 1'b0;
    rx_evt_o  = '0;
    link_up_o = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Report tasks, entered just after a falling edge
  // ----------------------------------------------------------------------
  // After a report the event bus shows its inverse, so stale data is
  // never mistaken for a fresh report
  task automatic send_tx(input psc_pkg::psc_tx_evt_t e);
    tx_done_o = 1'b1;
    tx_evt_o  = e;
    @(negedge core_clk_i);
    tx_done_o = 1'b0;
    tx_evt_o  = ~e;
    @(negedge core_clk_i); // Idle, so the strobe never re-rises at once
  endtask

  // Receive report, one per cycle at most
  task automatic send_rx(input psc_pkg::psc_rx_evt_t e);
    rx_done_o = 1'b1;
    rx_evt_o  = e;
    @(negedge core_clk_i);
    rx_done_o = 1'b0;
    rx_evt_o  = ~e;
  endtask

  // One late collision seen past the first 512 bits
  task automatic late_coll();
    tx_late_o = 1'b1;
    @(negedge core_clk_i);
    tx_late_o = 1'b0;
    @(negedge core_clk_i);
  endtask

  // Link held up for a number of cycles, then dropped
  task automatic link_pulse(input int n);
    link_up_o = 1'b1;
    repeat (n) @(negedge core_clk_i);
    link_up_o = 1'b0;
  endtask
endmodule

// ==== bench/psc_port_stats_tb.sv ====
// Self-checking testbench for the per-port statistics counters
`timescale 1ns/10ps

module psc_port_stats_tb;
  // ----------------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic tx_done, tx_late, rx_done, link_up;
  psc_pkg::psc_tx_evt_t tx_evt;
  psc_pkg::psc_rx_evt_t rx_evt;
  logic [13:0] max_frame_i = 14'h05ee;
  logic clr_port_i = 1'b0;
  logic clr_all_i = 1'b0;
  logic [7:0] clr_sel_i = 8'h00;
  logic rd_en_i = 1'b0;
  logic [4:0] rd_addr_i = 5'h00;
  logic [7:0] rd_data_o;
  logic rd_valid_o, rx_drop_o, link_up_o;
  logic [7:0] exp_cnt [0:31];
  int bad_count = 0;
  int n_compared = 0;

  // Narrow counters and a short uptime tick keep wrap and uptime reachable
  always #5 core_clk_i = ~core_clk_i;

  psc_mac_model u_mac (
    .core_clk_i(core_clk_i), .tx_done_o(tx_done), .tx_evt_o(tx_evt),
    .tx_late_o(tx_late), .rx_done_o(rx_done), .rx_evt_o(rx_evt),
    .link_up_o(link_up)
  );

  psc_port_stats #(.CNT_W(8), .PORT_ID(8'h03), .TICK_CYC(10)) u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .tx_done_i(tx_done), .tx_evt_i(tx_evt), .tx_late_coll_i(tx_late),
    .rx_done_i(rx_done), .rx_evt_i(rx_evt), .max_frame_i(max_frame_i),
    .link_up_i(link_up), .clr_port_i(clr_port_i), .clr_all_i(clr_all_i),
    .clr_sel_i(clr_sel_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .rx_drop_o(rx_drop_o), .link_up_o(link_up_o)
  );

  // ----------------------------------------------------------------------
  // Shared helpers, entered just after a falling edge, except wrap_up from the watchdog, entered after a rising edge
  // ----------------------------------------------------------------------
  task automatic wrap_up();
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, got);
    n_compared++;
    if (got !== ex) begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      bad_count++;
    end
  endtask

  // Read answers exactly one cycle after the request edge
  task automatic rd_chk(input logic [4:0] a);
    rd_en_i   = 1'b1;
    rd_addr_i = a;
    @(negedge core_clk_i);
    chk("rd_valid_o", 32'h1, {31'h0, rd_valid_o});
    chk($sformatf("counter %0d", a), {24'h0, exp_cnt[a]},
        {24'h0, rd_data_o});
    rd_en_i = 1'b0;
    // One idle cycle, so a following read raises the request afresh
    @(negedge core_clk_i);
    chk("rd_valid_o", 32'h0, {31'h0, rd_valid_o});
  endtask

  // Twice in a row, so a read that disturbs a counter shows up
  task automatic chk_all();
    for (int i = 0; i < 32; i++) rd_chk(i[4:0]);
    for (int i = 0; i < 32; i++) rd_chk(i[4:0]);
  endtask

  task automatic tx(input logic [10:0] v);
    psc_pkg::psc_tx_evt_t e;
    e = psc_pkg::psc_tx_evt_t'(v);
    u_mac.send_tx(e);
    exp_cnt[0]  += e.good;
    exp_cnt[1]  += e.good & e.mcast;
    exp_cnt[2]  += e.good & e.bcast;
    exp_cnt[3]  += e.pause;
    exp_cnt[4]  += e.vlan;
    exp_cnt[10] += e.good & (e.coll_cnt == 5'h01);
    exp_cnt[11] += e.good & (e.coll_cnt > 5'h01);
    exp_cnt[12] += e.excess;
  endtask

  // Expected classes worked out from flags, length and max_frame_i alone
  task automatic rx(input logic [19:0] v);
    psc_pkg::psc_rx_evt_t e;
    logic g;
    e = psc_pkg::psc_rx_evt_t'(v);
    g = !e.crc_err && !e.len_err && e.len >= 14'h0040 && e.len <= max_frame_i;
    u_mac.send_rx(e);
    chk("rx_drop_o", {31'h0, e.len > max_frame_i},
        {31'h0, rx_drop_o});
    @(negedge core_clk_i);
    exp_cnt[5]  += g;
    exp_cnt[6]  += g & e.mcast;
    exp_cnt[7]  += g & e.bcast;
    exp_cnt[8]  += e.pause;
    exp_cnt[9]  += e.ctrl & !e.pause;
    exp_cnt[14] += e.crc_err;
    exp_cnt[15] += e.len_err;
    exp_cnt[16] += e.len < 14'h0040;
    exp_cnt[17] += e.len == 14'h0040;
    exp_cnt[18] += e.len >= 14'h0041 && e.len <= 14'h007f;
    exp_cnt[19] += e.len >= 14'h0080 && e.len <= 14'h00ff;
    exp_cnt[20] += e.len >= 14'h0100 && e.len <= 14'h01ff;
    exp_cnt[21] += e.len >= 14'h0200 && e.len <= 14'h03ff;
    exp_cnt[22] += e.len >= 14'h0400 && e.len <= 14'h05ee;
    exp_cnt[23] += e.len > max_frame_i;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Mixed transmit reports, two failed ones and late collisions
  task automatic sc_tx();
    tx(11'b100000_00000);
    tx(11'b110010_00001);
    tx(11'b101000_00010);
    tx(11'b100100_11111);
    tx(11'b000011_10000);
    tx(11'b001110_00001);
    u_mac.late_coll();
    u_mac.late_coll();
    exp_cnt[13] += 8'h02;
    ce_i = 1'b0;
    u_mac.send_tx(psc_pkg::psc_tx_evt_t'(11'b100000_00000));
    ce_i = 1'b1;
    chk_all();
  endtask

  // Every size boundary, error mixes, control versus pause, oversize
  task automatic sc_rx();
    logic [19:0] t [0:14];
    t = '{{6'h08, 14'h0040}, {6'h04, 14'h007f}, {6'h20, 14'h003c},
          {6'h01, 14'h0080}, {6'h03, 14'h00ff}, {6'h21, 14'h0100},
          {6'h10, 14'h01ff}, {6'h00, 14'h0200}, {6'h00, 14'h03ff},
          {6'h00, 14'h0400}, {6'h00, 14'h05ee}, {6'h08, 14'h07d0},
          {6'h00, 14'h05ef}, {6'h00, 14'h003f}, {6'h14, 14'h0041}};
    for (int i = 0; i < 15; i++) rx(t[i]);
    max_frame_i = 14'h03e8;
    rx({6'h00, 14'h04b0});
    max_frame_i = 14'h05ee;
    chk_all();
  endtask

  // Clear aimed elsewhere, then at this port, then all with an event
  task automatic sc_clear();
    clr_port_i = 1'b1;
    clr_sel_i  = 8'h04;
    @(negedge core_clk_i);
    clr_port_i = 1'b0;
    clr_sel_i = 8'h03;
    chk_all();
    clr_port_i = 1'b1;
    @(negedge core_clk_i);
    clr_port_i = 1'b0;
    foreach (exp_cnt[i]) exp_cnt[i] = 8'h00;
    chk_all();
    tx(11'b100000_00000);
    clr_all_i = 1'b1;
    u_mac.send_tx(psc_pkg::psc_tx_evt_t'(11'b110000_00000));
    clr_all_i = 1'b0;
    foreach (exp_cnt[i]) exp_cnt[i] = 8'h00;
    chk_all();
  endtask

  // Link up for 105 cycles at a 10-cycle tick gives ten uptime units
  task automatic sc_uptime();
    fork
      u_mac.link_pulse(105);
      begin
        repeat (6) @(negedge core_clk_i);
        chk("link_up_o", 32'h1, {31'h0, link_up_o});
      end
    join
    repeat (6) @(negedge core_clk_i);
    chk("link_up_o", 32'h0, {31'h0, link_up_o});
    exp_cnt[24] = 8'h0a;
    rd_chk(5'h18);
  endtask

  // 257 good frames on an 8-bit counter leave it at one
  task automatic sc_wrap();
    for (int i = 0; i < 257; i++) tx(11'b100000_00000);
    rd_chk(5'h00);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    foreach (exp_cnt[i]) exp_cnt[i] = 8'h00;
    repeat (20) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    chk_all();
    sc_tx();
    sc_rx();
    sc_clear();
    sc_uptime();
    sc_wrap();
    wrap_up();
  end

  // A hang counts as a mismatch and still reaches the verdict
  initial begin
    repeat (60000) @(posedge core_clk_i);
    bad_count++;
    wrap_up();
  end
endmodule
